// ### nfh_host.sv
// Host controller driving a multiplexed 8-bit NAND flash over its pins, ordered over Wishbone
module nfh_host
  import nfh_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // Wishbone slave
  input wire logic WB_CYC,
  input wire logic WB_STB,
  input wire logic WB_WE,
  input wire logic [3:0] WB_ADR,
  input wire logic [3:0] WB_SEL,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK,
  // Device pins
  output nfh_pkg::nfh_pins_out_t PINS,
  input wire logic [7:0] IO_IN,
  input wire logic READY_BUSY_N
);
  import nfh_pkg::*;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [2:0] ctrl;
  nfh_addr_t addr;
  logic [7:0] cmd_byte;
  nfh_op_t op;
  logic [7:0] rdata;
  logic go;
  nfh_state_t state;
  logic [2:0] acount;
  logic strobe_start;
  logic strobe_low;
  logic strobe_done;
  logic busy;
  logic ready_q;
  logic wb_req;
  logic [7:0] next_byte;

  assign wb_req = WB_CYC && WB_STB && !WB_ACK;
  // A pending start counts as busy, so status and command gating see it
  assign busy = state != ST_IDLE || go;

  // ----------------------------------------------------------------
  // Wishbone slave: one registered ack after one wait state, dropped the next cycle
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      WB_ACK <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end else begin
      WB_ACK <= wb_req;
      WB_DAT_O <= 32'h0000_0000;
      if (wb_req && !WB_WE) begin
        if (WB_ADR == REG_CTRL) begin
          WB_DAT_O <= {8'h00, rdata, 6'h00, ready_q, busy, 5'h00, ctrl};
        end else if (WB_ADR == REG_ADDR_LO) begin
          WB_DAT_O <= {13'h0000, addr.wordline_index, addr.column_addr};
        end else if (WB_ADR == REG_ADDR_HI) begin
          WB_DAT_O <= {21'h000000, addr.block_index};
        end else if (WB_ADR == REG_CMD) begin
          WB_DAT_O <= {21'h000000, op, cmd_byte};
        end
      end
    end
  end

  // Writes; a command write while busy is dropped
  // Start request stays pending until the device reports ready
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      ctrl <= CTRL_RESET[2:0];
      addr <= '0;
      cmd_byte <= 8'h00;
      op <= OP_CMD;
      go <= 1'b0;
    end else begin
      if (go && state == ST_IDLE && ready_q) begin
        go <= 1'b0;
      end
      if (wb_req && WB_WE && WB_SEL[0]) begin
        if (WB_ADR == REG_CTRL) begin
          ctrl <= WB_DAT_I[2:0];
        end else if (WB_ADR == REG_CMD && !busy) begin
          cmd_byte <= WB_DAT_I[7:0];
          op <= nfh_op_t'(WB_DAT_I[CMD_OP_LSB +: 3]);
          go <= 1'b1;
        end else if (WB_ADR == REG_ADDR_LO) begin
          addr.column_addr <= WB_DAT_I[COL_BITS-1:0];
          addr.wordline_index <= WB_DAT_I[COL_BITS +: WL_BITS];
        end else if (WB_ADR == REG_ADDR_HI) begin
          addr.block_index <= WB_DAT_I[BLK_BITS-1:0];
        end
      end
    end
  end

  // Pins are inputs synchronous to CLK
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= READY_BUSY_N;
    end
  end

  // ----------------------------------------------------------------
  // Strobe sequencer
  // ----------------------------------------------------------------
  nfh_strobe u_strobe (
    .CLK(CLK),
    .RESET(RESET),
    .start(strobe_start),
    .phase_low(strobe_low),
    .done(strobe_done)
  );

  always_comb begin
    next_byte = cmd_byte;
    if (op == OP_ADDR) begin
      // Spare-region column form is software's duty
      next_byte = addr_byte(addr, acount);
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      state <= ST_IDLE;
      acount <= 3'd0;
      strobe_start <= 1'b0;
    end else begin
      strobe_start <= 1'b0;
      case (state)
        ST_IDLE: begin
          acount <= 3'd0;
          // Wait for ready so no strobe falls in a busy read
          if (go && ready_q) begin
            state <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          strobe_start <= 1'b1;
          state <= ST_LOW;
        end
        ST_LOW: begin
          if (strobe_done) begin
            state <= ST_NEXT;
          end
        end
        ST_NEXT: begin
          if (op == OP_ADDR && acount != 3'(ADDR_CYCLES - 1)) begin
            acount <= acount + 3'd1;
            state <= ST_SETUP;
          end else begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      PINS.cle <= 1'b0;
      PINS.ale <= 1'b0;
      PINS.chip_select_n <= 1'b1;
      PINS.write_strobe_n <= 1'b1;
      PINS.read_strobe_n <= 1'b1;
      PINS.write_protect_n <= 1'b0;
      PINS.io_out <= 8'h00;
      PINS.io_oe <= 1'b0;
    end else begin
      // Firm level always; follows ctrl[CTRL_WP_BIT] whatever the operation
      PINS.write_protect_n <= ctrl[CTRL_WP_BIT];
      PINS.chip_select_n <= !(busy || ctrl[CTRL_CE_BIT]);
      PINS.cle <= busy && op == OP_CMD;
      PINS.ale <= busy && op == OP_ADDR;
      PINS.io_out <= next_byte;
      // Drive only on write cycles; never overlaps a read
      PINS.io_oe <= busy && op != OP_RDATA;
      PINS.write_strobe_n <= !(strobe_low && op != OP_RDATA);
      PINS.read_strobe_n <= !(strobe_low && op == OP_RDATA);
    end
  end

  // Sample read byte at the end of the read-strobe low phase
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      rdata <= 8'h00;
    end else if (!PINS.read_strobe_n) begin
      rdata <= IO_IN;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_STROBES_EXCLUSIVE: assert property (@(posedge CLK) disable iff (RESET)
    !(!PINS.write_strobe_n && !PINS.read_strobe_n))
    else $error("Both strobes low");
  AST_CMD_LEVELS: assert property (@(posedge CLK) disable iff (RESET)
    $rose(PINS.write_strobe_n) && PINS.cle |-> !PINS.ale && !PINS.chip_select_n && PINS.read_strobe_n)
    else $error("Bad command cycle levels");
  AST_ADDR_LEVELS: assert property (@(posedge CLK) disable iff (RESET)
    !PINS.write_strobe_n && PINS.ale |-> !PINS.cle && !PINS.chip_select_n)
    else $error("Bad address cycle levels");
  AST_READ_LEVELS: assert property (@(posedge CLK) disable iff (RESET)
    !PINS.read_strobe_n |-> !PINS.cle && !PINS.ale && !PINS.chip_select_n && PINS.write_strobe_n && !PINS.io_oe)
    else $error("Bad read cycle levels");
  AST_NO_START_BUSY: assert property (@(posedge CLK) disable iff (RESET)
    state == ST_IDLE && go && !ready_q |=> state == ST_IDLE)
    else $error("Started while device busy");
  AST_WP_FOLLOWS: assert property (@(posedge CLK) disable iff (RESET)
    ctrl[CTRL_WP_BIT] |=> PINS.write_protect_n)
    else $error("Write protect not driven high");
  AST_FIVE_ADDR: assert property (@(posedge CLK) disable iff (RESET)
    state == ST_NEXT && op == OP_ADDR && acount != 3'd4 |=> state == ST_SETUP)
    else $error("Address sequence cut short");
  AST_CS_IN_CYCLE: assert property (@(posedge CLK) disable iff (RESET)
    state == ST_LOW |=> !PINS.chip_select_n)
    else $error("Strobe without chip select");

endmodule : nfh_host

// ### nfh_pkg.sv
// Package: constants, types and pin carriers for the NAND pin-bus host controller
package nfh_pkg;

  // ----------------------------------------------------------------
  // Register map (Wishbone word offsets, byte addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_CMD = 4'h4;
  localparam logic [3:0] REG_ADDR_LO = 4'h8;
  localparam logic [3:0] REG_ADDR_HI = 4'hc;

  // CTRL fields
  localparam int CTRL_WP_BIT = 0;
  localparam int CTRL_CE_BIT = 1;
  localparam int CTRL_MODIFY_BIT = 2;
  // CMD register fields: [7:0] byte, [10:8] operation
  localparam int CMD_OP_LSB = 8;
  // Status fields (read of REG_CTRL)
  localparam int STAT_BUSY_BIT = 8;
  localparam int STAT_RDY_BIT = 9;
  localparam int STAT_DATA_LSB = 16;

  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Address geometry
  // ----------------------------------------------------------------
  localparam int COL_BITS = 13;
  localparam int WL_BITS = 6;
  localparam int BLK_BITS = 11;
  localparam int ADDR_CYCLES = 5;

  // ----------------------------------------------------------------
  // Strobe timing at 10 MHz
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 10;
  localparam int STROBE_NS = 100;
  localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000 < 1 ? 1 :
                              (STROBE_NS * CLK_MHZ + 999) / 1000;

  typedef enum logic [2:0] {
    OP_CMD = 3'b000,
    OP_ADDR = 3'b001,
    OP_WDATA = 3'b010,
    OP_RDATA = 3'b011
  } nfh_op_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SETUP = 3'b001,
    ST_LOW = 3'b010,
    ST_HIGH = 3'b011,
    ST_NEXT = 3'b100
  } nfh_state_t;

  // Pins driven toward the device
  typedef struct packed {
    logic cle;
    logic ale;
    logic chip_select_n;
    logic write_strobe_n;
    logic read_strobe_n;
    logic write_protect_n;
    logic [7:0] io_out;
    logic io_oe;
  } nfh_pins_out_t;

  typedef struct packed {
    logic [COL_BITS-1:0] column_addr;
    logic [WL_BITS-1:0] wordline_index;
    logic [BLK_BITS-1:0] block_index;
  } nfh_addr_t;

  // Byte n of the five address cycles
  function automatic logic [7:0] addr_byte(input nfh_addr_t a, input logic [2:0] n);
    logic [7:0] b;
    b = 8'h00;
    case (n)
      3'd0: b = a.column_addr[7:0];
      3'd1: b = {3'b000, a.column_addr[12:8]};
      3'd2: b = {a.block_index[1:0], a.wordline_index};
      3'd3: b = a.block_index[9:2];
      3'd4: b = {7'b0000000, a.block_index[10]};
      default: b = 8'h00;
    endcase
    return b;
  endfunction : addr_byte

endpackage : nfh_pkg

// ### nfh_strobe.sv
// Strobe pulse timer: one low phase and one high phase of a write or read strobe
module nfh_strobe
  import nfh_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // Control
  input wire logic start,
  output logic phase_low,
  output logic done
);
  import nfh_pkg::*;

  logic [7:0] count;
  logic second;

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      count <= 8'h00;
      phase_low <= 1'b0;
      second <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && !phase_low && !second) begin
        phase_low <= 1'b1;
        count <= 8'(STROBE_CYC - 1);
      end else if (count != 8'h00) begin
        count <= count - 8'h01;
      end else if (phase_low) begin
        phase_low <= 1'b0;
        second <= 1'b1;
        count <= 8'(STROBE_CYC - 1);
      end else if (second) begin
        second <= 1'b0;
        done <= 1'b1;
      end
    end
  end

endmodule : nfh_strobe

// ### nfh_flash_model.sv
// Behavioural model of the flash device on the far side of the pin bus
module nfh_flash_model
  import nfh_pkg::*;
#(
  parameter int BUSY_CYC = 20
)
(
  // Clock for busy timing only
  input wire logic clk,
  // Pins from the host, plus guard enable and supply status
  input wire nfh_pkg::nfh_pins_out_t pins,
  input wire logic [7:0] io,
  input wire logic volatile_guard_enable,
  input wire logic supply_ok,
  // Pins to the host
  output logic [7:0] dev_io,
  output logic rb_pull_low
);
  timeunit 1ns;
  timeprecision 1ns;
  import nfh_pkg::*;
  logic [7:0] arr [0:15];
  logic [7:0] wbuf [0:15];
  logic [7:0] ab [0:4];
  logic [7:0] dout;
  logic [12:0] col;
  logic [12:0] col_start;
  logic [16:0] row;
  logic busy;
  logic guard;
  int acnt;
  int cmd_count;
  int bad;
  event go_busy;
  // ------------------------------------------------------------
  // Selection and bus drive
  // ------------------------------------------------------------
  wire logic sel = !pins.chip_select_n && !busy && supply_ok;
  wire logic drv = sel && !pins.read_strobe_n && pins.write_strobe_n;
  // Released lines show the inverse so a stale byte never passes
  assign dev_io = drv ? dout : ~dout;
  assign rb_pull_low = busy;
  initial begin
    for (int i = 0; i < 16; i++) begin
      arr[i] = 8'(i * 7 + 3);
      wbuf[i] = arr[i];
    end
    busy = 1'b0;
    acnt = 0;
    cmd_count = 0;
    bad = 0;
    col = 13'h0;
    dout = 8'h00;
    #1 guard = volatile_guard_enable;
  end
  initial forever begin
    @(go_busy);
    busy = 1'b1;
    repeat (BUSY_CYC) @(posedge clk);
    @(negedge clk);
    busy = 1'b0;
  end
  // ------------------------------------------------------------
  // Latching on the write strobe
  // ------------------------------------------------------------
  always @(posedge pins.write_strobe_n) begin
    if (sel && pins.cle && !pins.ale) begin
      cmd_count++;
      acnt = 0;
      if (io == 8'h30) ->go_busy;
      // Write-protect pin is looked at live; guard is latched once at start
      if (io == 8'h10 && pins.write_protect_n && !guard) begin
        for (int i = 0; i < 16; i++) arr[i] = wbuf[i];
        ->go_busy;
      end
    end else if (sel && pins.ale && !pins.cle && acnt < 5) begin
      ab[acnt] = io;
      acnt++;
      if (acnt == 2) col = {ab[1][4:0], ab[0]};
      col_start = col;
      if (acnt == 5) row = {ab[4][0], ab[3], ab[2]};
    end else if (sel && !pins.cle && !pins.ale) begin
      wbuf[col[3:0]] = io;
      col++;
    end
  end
  // ------------------------------------------------------------
  // Data out on the read strobe
  // ------------------------------------------------------------
  always @(negedge pins.read_strobe_n) begin
    if (sel && !pins.cle && !pins.ale) begin
      dout = arr[col[3:0]];
      col++;
    end
  end
  always @(negedge pins.read_strobe_n or negedge pins.write_strobe_n) begin
    if (busy) bad++;
  end
endmodule : nfh_flash_model

// ### nfh_host_test.sv
// Self-checking testbench of the pin-bus host controller
module nfh_host_test;
  timeunit 1ns;
  timeprecision 1ns;
  import nfh_pkg::*;
  logic CLK = 1'b0;
  logic RESET = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [3:0] adr = 4'h0, sel = 4'h0;
  logic [31:0] dat = 32'h0, rd_dat, r;
  logic ack;
  nfh_pins_out_t pins;
  logic [7:0] dev_io, io_bus;
  logic rb_low;
  int errors = 0, samples_checked = 0, cycles = 0, c0;
  always #50 CLK = ~CLK;
  assign io_bus = pins.io_oe ? pins.io_out : dev_io;
  nfh_host uut (.CLK(CLK), .RESET(RESET), .WB_CYC(cyc), .WB_STB(stb), .WB_WE(we), .WB_ADR(adr),
    .WB_SEL(sel), .WB_DAT_I(dat), .WB_DAT_O(rd_dat), .WB_ACK(ack), .PINS(pins), .IO_IN(io_bus),
    .READY_BUSY_N(!rb_low));
  nfh_flash_model u_dev (.clk(CLK), .pins(pins), .io(io_bus), .volatile_guard_enable(1'b0),
    .supply_ok(1'b1), .dev_io(dev_io), .rb_pull_low(rb_low));
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic conclude;
    $display("Checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge CLK);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hf;
    dat <= d;
    do @(posedge CLK); while (ack !== 1'b1);
    r = rd_dat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb
  task automatic idle_wait;
    int n;
    n = 0;
    r = 32'h100;
    while (r[STAT_BUSY_BIT] !== 1'b0 && n < 300) begin
      wb(1'b0, REG_CTRL, 32'h0);
      n++;
    end
    if (n == 300) chk(r, 32'h0, "busy timeout");
  endtask : idle_wait
  task automatic op(input logic [2:0] o, input logic [7:0] b);
    idle_wait();
    wb(1'b1, REG_CMD, {21'h0, o, b});
    idle_wait();
  endtask : op
  task automatic addr(input logic [12:0] c, input logic [5:0] wl, input logic [10:0] blk);
    wb(1'b1, REG_ADDR_LO, {13'h0, wl, c});
    wb(1'b1, REG_ADDR_HI, {21'h0, blk});
    op(OP_ADDR, 8'h00);
  endtask : addr
  task automatic rd_check(input logic [12:0] c, input logic [5:0] wl, input logic [10:0] blk,
                          input logic [15:0] e);
    op(OP_CMD, 8'h00);
    addr(c, wl, blk);
    op(OP_CMD, 8'h30);
    chk(32'(u_dev.col_start), 32'(c), "column");
    chk(32'(u_dev.row), 32'({blk, wl}), "row");
    for (int i = 0; i < 2; i++) begin
      op(OP_RDATA, 8'h00);
      wb(1'b0, REG_CTRL, 32'h0);
      chk(32'(r[23:16]), 32'(e[i*8 +: 8]), "read byte");
    end
  endtask : rd_check
  task automatic prog(input logic [12:0] c, input logic [15:0] d);
    op(OP_CMD, 8'h80);
    addr(c, 6'h3f, 11'h7ff);
    op(OP_WDATA, d[7:0]);
    op(OP_WDATA, d[15:8]);
    op(OP_CMD, 8'h10);
  endtask : prog
  // ------------------------------------------------------------
  // Timeout and main sequence
  // ------------------------------------------------------------
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 40000) begin
      errors++;
      conclude();
    end
  end
  initial begin
    repeat (8) @(posedge CLK);
    RESET <= 1'b0;
    chk(32'({pins.chip_select_n, pins.write_protect_n, pins.io_oe}), 32'h4, "reset pins");
    wb(1'b0, REG_CTRL, 32'h0);
    chk(r, 32'h200, "ctrl reset");
    wb(1'b0, 4'h2, 32'h0);
    chk(r, 32'h0, "unmapped");
    wb(1'b1, REG_CTRL, 32'h3);
    @(posedge CLK);
    chk(32'({pins.chip_select_n, pins.write_protect_n}), 32'h1, "selected");
    rd_check(13'h1005, 6'h2a, 11'h5b3, {8'(6 * 7 + 3), 8'(5 * 7 + 3)});
    wb(1'b0, REG_ADDR_LO, 32'h0);
    chk(r, {13'h0, 6'h2a, 13'h1005}, "addr lo readback");
    wb(1'b0, REG_ADDR_HI, 32'h0);
    chk(r, {21'h0, 11'h5b3}, "addr hi readback");
    prog(13'h0003, 16'hd4c3);
    rd_check(13'h0003, 6'h3f, 11'h7ff, 16'hd4c3);
    wb(1'b1, REG_CTRL, 32'h2);
    prog(13'h0003, 16'h2211);
    chk(32'(pins.write_protect_n), 32'h0, "wp pin");
    rd_check(13'h0003, 6'h3f, 11'h7ff, 16'hd4c3);
    c0 = u_dev.cmd_count;
    wb(1'b1, REG_CMD, {21'h0, OP_CMD, 8'h70});
    wb(1'b1, REG_CMD, {21'h0, OP_CMD, 8'h70});
    op(OP_CMD, 8'h00);
    chk(32'(u_dev.cmd_count - c0), 32'h2, "busy refusal");
    chk(32'(u_dev.bad), 32'h0, "strobe while busy");
    wb(1'b1, REG_CTRL, 32'h0);
    @(posedge CLK);
    chk(32'(pins.chip_select_n), 32'h1, "standby");
    conclude();
  end
endmodule : nfh_host_test
